// ===== core/sos_output_status.sv
// output, relay, switch decode and status logic of the speed monitor
`timescale 1ns/1ps
`default_nettype none
// Function
// - four control outputs, each invertible, switched by stored switching points.
// - any error forces all four control outputs low, inversion ignored.
// - two relay coils driven together; series contact closes only with both.
// - relays energized only in fault-free normal run; released on error or trip.
// - forcibly guided closed feedback contact is read to watch the relays.
// - each switching point has a configurable hysteresis against chatter.
// - per-output lock holds the switched state after the point is passed.
// - switch a and b on is normal, a only is programming, a off factory.
// - ready after 2 s with report switch on, else self-test report, 8 s.
// - yellow lamp on in self-test or error, slow flash off-normal, else off.
// - parameters are set up from outside over the register port.
// - mode 0 dual input maps sensor one and two to the two encoder inputs.
// - mode 0 single-encoder variant bridges sensor two onto sensor one.
module sos_output_status #(
  parameter int READY_SHORT = sos_pkg::READY_SHORT_CYC,
  parameter int READY_LONG = sos_pkg::READY_LONG_CYC,
  parameter int RELAY_SETTLE = sos_pkg::RELAY_SETTLE_CYC,
  parameter int FLASH_HALF = sos_pkg::FLASH_HALF_CYC,
  parameter bit SINGLE_ENCODER = 1'b0
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic runSelectSwitchA,
  input wire logic selftestReportSwitch,
  input wire logic runSelectSwitchB,
  input wire logic relayFeedback,
  input wire logic errorIn,
  input wire logic selfTestPass,
  input wire logic [sos_pkg::FREQ_W-1:0] freqSinCos1,
  input wire logic [sos_pkg::FREQ_W-1:0] freqSinCos2,
  output logic [sos_pkg::NUM_OUT-1:0] ctrlOut,
  output logic relayCoilA,
  output logic relayCoilB,
  output logic ledYellow,
  output logic selfTestMsg,
  output logic [sos_pkg::FREQ_W-1:0] sensorFreq1,
  output logic [sos_pkg::FREQ_W-1:0] sensorFreq2,
  output logic irq
);
  import sos_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [3:0] pinMeta_r;
  logic [3:0] pinSync_r;
  logic swA;
  logic swReport;
  logic swB;
  logic fbClosed;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      // feedback starts at its released level, switches off
      pinMeta_r <= 4'h8;
      pinSync_r <= 4'h8;
    end else begin
      pinMeta_r <= {relayFeedback, runSelectSwitchB, selftestReportSwitch, runSelectSwitchA};
      pinSync_r <= pinMeta_r;
    end
  end

  assign swA = pinSync_r[0];
  assign swReport = pinSync_r[1];
  assign swB = pinSync_r[2];
  assign fbClosed = pinSync_r[3];

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [31:0] point_r [NUM_OUT+1];
  logic [ST_W-1:0] status_r;
  logic [ST_W-1:0] mask_r;
  logic [ST_W-1:0] statusSet;
  logic lockClr_r;
  logic wrEn;
  logic setupPhase;

  function automatic int pointIndex(input logic [7:0] addr);
    if (addr >= ADDR_POINT0 && addr <= ADDR_RELAYPT && addr[1:0] == 2'b00) begin
      return int'((addr - ADDR_POINT0) >> 2);
    end
    return -1;
  endfunction

  function automatic logic isMapped(input logic [7:0] addr);
    return addr == ADDR_CTRL || addr == ADDR_STATUS || addr == ADDR_MASK
      || addr == ADDR_STATE || addr == ADDR_LOCKCLR || pointIndex(addr) >= 0;
  endfunction

  assign setupPhase = psel && !penable;
  assign wrEn = psel && penable && pready && pwrite;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= CTRL_RST;
      mask_r <= MASK_RST;
      lockClr_r <= 1'b0;
    end else begin
      lockClr_r <= wrEn && paddr == ADDR_LOCKCLR && pwdata[0];
      if (wrEn && paddr == ADDR_CTRL) begin
        ctrl_r <= pwdata;
      end
      if (wrEn && paddr == ADDR_MASK) begin
        mask_r <= pwdata[ST_W-1:0];
      end
    end
  end

  for (genvar i = 0; i <= NUM_OUT; i++) begin : gPointReg
    always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
        point_r[i] <= POINT_RST;
      end else if (wrEn && pointIndex(paddr) == i) begin
        point_r[i] <= pwdata;
      end
    end
  end

  // status clears by writing ones, a set in the same cycle wins
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      status_r <= '0;
    end else if (wrEn && paddr == ADDR_STATUS) begin
      status_r <= (status_r & ~pwdata[ST_W-1:0]) | statusSet;
    end else begin
      status_r <= status_r | statusSet;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |((status_r | statusSet) & mask_r);
    end
  end

  // ---------------------------------------------------------------
  // apb answer, no wait state
  // ---------------------------------------------------------------
  logic [31:0] stateWord;
  logic ready_r;
  logic relayFault_r;
  logic relayCmd_r;
  sos_run_type runState_r;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setupPhase;
      pslverr <= setupPhase && !isMapped(paddr);
      prdata <= 32'h0000_0000;
      if (setupPhase && !pwrite) begin
        if (paddr == ADDR_CTRL) begin
          prdata <= ctrl_r;
        end else if (paddr == ADDR_STATUS) begin
          prdata <= 32'(status_r);
        end else if (paddr == ADDR_MASK) begin
          prdata <= 32'(mask_r);
        end else if (paddr == ADDR_STATE) begin
          prdata <= stateWord;
        end else if (pointIndex(paddr) >= 0) begin
          prdata <= point_r[pointIndex(paddr)];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // run state and readiness
  // ---------------------------------------------------------------
  logic [31:0] readyCnt_r;
  logic [31:0] readyLimit;
  logic live;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      runState_r <= RUN_FACTORY;
    end else if (!swA) begin
      runState_r <= RUN_FACTORY;
    end else if (swB) begin
      runState_r <= RUN_NORMAL;
    end else begin
      runState_r <= RUN_PROGRAM;
    end
  end

  assign readyLimit = swReport ? 32'(READY_SHORT) : 32'(READY_LONG);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      readyCnt_r <= 32'h0000_0000;
      ready_r <= 1'b0;
      selfTestMsg <= 1'b0;
    end else begin
      if (!ready_r && readyCnt_r >= readyLimit - 32'd1) begin
        ready_r <= 1'b1;
      end
      if (!ready_r) begin
        readyCnt_r <= readyCnt_r + 32'd1;
      end
      selfTestMsg <= !ready_r && !swReport;
    end
  end

  assign live = ready_r && selfTestPass;

  // ---------------------------------------------------------------
  // sensor channel mapping
  // ---------------------------------------------------------------
  logic bridge;

  assign bridge = SINGLE_ENCODER && ctrl_r[CTRL_MODE_LSB +: CTRL_MODE_W] == 4'h0;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sensorFreq1 <= 16'h0000;
      sensorFreq2 <= 16'h0000;
    end else begin
      sensorFreq1 <= freqSinCos1;
      sensorFreq2 <= bridge ? freqSinCos1 : freqSinCos2;
    end
  end

  // ---------------------------------------------------------------
  // switching points
  // ---------------------------------------------------------------
  logic [NUM_OUT:0] pointState;

  for (genvar i = 0; i <= NUM_OUT; i++) begin : gPoint
    sos_sw_if sw ();
    assign sw.freq = point_r[i][PT_CHSEL_BIT] ? sensorFreq2 : sensorFreq1;
    assign sw.thresh = point_r[i][PT_THR_LSB +: FREQ_W];
    assign sw.hyst = point_r[i][PT_HYST_LSB +: HYST_W];
    assign sw.overSel = point_r[i][PT_OVER_BIT];
    assign sw.lockEn = (i < NUM_OUT) ? ctrl_r[CTRL_LOCK_LSB + i] : ctrl_r[CTRL_RELAYLOCK_BIT];
    assign sw.lockClr = lockClr_r;
    assign sw.active = live;
    assign pointState[i] = sw.state;
    sos_switch_point uPoint (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .sw(sw.point)
    );
  end

  // ---------------------------------------------------------------
  // control outputs and relays
  // ---------------------------------------------------------------
  logic errAny;
  logic relayTrip;
  logic relayCmd_nxt;
  logic [31:0] settleCnt_r;
  logic fbMismatch;

  assign errAny = errorIn || relayFault_r;
  assign relayTrip = pointState[NUM_OUT];
  assign relayCmd_nxt = live && !errAny && runState_r == RUN_NORMAL && !relayTrip;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrlOut <= '0;
    end else if (errAny || !live) begin
      ctrlOut <= '0;
    end else begin
      ctrlOut <= pointState[NUM_OUT-1:0] ^ ctrl_r[CTRL_INV_LSB +: NUM_OUT];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      relayCmd_r <= 1'b0;
      relayCoilA <= 1'b0;
      relayCoilB <= 1'b0;
    end else begin
      relayCmd_r <= relayCmd_nxt;
      relayCoilA <= relayCmd_nxt;
      relayCoilB <= relayCmd_nxt;
    end
  end

  // closed feedback contact must be the opposite of the coil
  assign fbMismatch = fbClosed == relayCmd_r;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      settleCnt_r <= 32'h0000_0000;
      relayFault_r <= 1'b0;
    end else begin
      if (!fbMismatch || relayCmd_r != relayCmd_nxt) begin
        settleCnt_r <= 32'h0000_0000;
      end else if (settleCnt_r < 32'(RELAY_SETTLE) - 32'd1) begin
        settleCnt_r <= settleCnt_r + 32'd1;
      end else begin
        relayFault_r <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // yellow lamp and events
  // ---------------------------------------------------------------
  logic [31:0] flashCnt_r;
  logic flashPhase_r;
  logic errPrev_r;
  logic readyPrev_r;
  logic tripPrev_r;
  logic faultPrev_r;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      flashCnt_r <= 32'h0000_0000;
      flashPhase_r <= 1'b0;
    end else if (flashCnt_r >= 32'(FLASH_HALF) - 32'd1) begin
      flashCnt_r <= 32'h0000_0000;
      flashPhase_r <= !flashPhase_r;
    end else begin
      flashCnt_r <= flashCnt_r + 32'd1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ledYellow <= 1'b1;
    end else if (!live || errAny) begin
      ledYellow <= 1'b1;
    end else begin
      ledYellow <= runState_r != RUN_NORMAL && flashPhase_r;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      errPrev_r <= 1'b0;
      readyPrev_r <= 1'b0;
      tripPrev_r <= 1'b0;
      faultPrev_r <= 1'b0;
    end else begin
      errPrev_r <= errorIn;
      readyPrev_r <= live;
      tripPrev_r <= relayTrip;
      faultPrev_r <= relayFault_r;
    end
  end

  always_comb begin
    statusSet = '0;
    statusSet[ST_RELAY_FAULT] = relayFault_r && !faultPrev_r;
    statusSet[ST_ERROR] = errorIn && !errPrev_r;
    statusSet[ST_READY] = live && !readyPrev_r;
    statusSet[ST_TRIP] = relayTrip && !tripPrev_r;
  end

  assign stateWord = {14'h0000, fbClosed, relayFault_r, relayCmd_r, errAny, selfTestPass,
    ready_r, runState_r, 1'b0, pointState, ctrlOut};

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_errSeen;
    errAny;
  endsequence

  sequence s_mismatchDone;
    fbMismatch && relayCmd_r == relayCmd_nxt && settleCnt_r == 32'(RELAY_SETTLE) - 32'd1;
  endsequence

  property p_errOutLow;
    s_errSeen |=> ctrlOut == '0;
  endproperty
  a_errOutLow: assert property (p_errOutLow) else $error("outputs not low on error");

  property p_coilPair;
    relayCoilA == relayCoilB && relayCoilA == relayCmd_r;
  endproperty
  a_coilPair: assert property (p_coilPair) else $error("relay coils differ");

  property p_relayOff;
    (errAny || (relayTrip && live)) |=> !relayCoilA && !relayCoilB;
  endproperty
  a_relayOff: assert property (p_relayOff) else $error("relay held on error or trip");

  property p_relayFault;
    s_mismatchDone |=> relayFault_r ##1 (ctrlOut == '0 && !relayCoilA);
  endproperty
  a_relayFault: assert property (p_relayFault) else $error("feedback fault missed");

  property p_safeBeforeReady;
    !live |=> ctrlOut == '0 && !relayCoilA && ledYellow;
  endproperty
  a_safeBeforeReady: assert property (p_safeBeforeReady) else $error("live before ready");

  property p_factory;
    !swA |=> runState_r == RUN_FACTORY;
  endproperty
  a_factory: assert property (p_factory) else $error("factory state not decoded");

  property p_readyTime;
    (!ready_r && readyCnt_r == readyLimit - 32'd2) |=> !ready_r ##1 ready_r;
  endproperty
  a_readyTime: assert property (p_readyTime) else $error("readiness time wrong");

  property p_ledNormal;
    (live && !errAny && runState_r == RUN_NORMAL) |=> !ledYellow;
  endproperty
  a_ledNormal: assert property (p_ledNormal) else $error("lamp lit in normal run");

  property p_bridge;
    bridge |=> sensorFreq2 == $past(freqSinCos1);
  endproperty
  a_bridge: assert property (p_bridge) else $error("sensor two not bridged");
endmodule
`default_nettype wire

// ===== core/sos_pkg.sv
// constants and types of the safe output and status block
package sos_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int READY_SHORT_MS = 2000;
  localparam int READY_LONG_MS = 8000;
  localparam int RELAY_SETTLE_MS = 20;
  localparam int FLASH_HALF_MS = 500;
  localparam int READY_SHORT_CYC = READY_SHORT_MS * CYC_PER_MS;
  localparam int READY_LONG_CYC = READY_LONG_MS * CYC_PER_MS;
  localparam int RELAY_SETTLE_CYC = RELAY_SETTLE_MS * CYC_PER_MS;
  localparam int FLASH_HALF_CYC = FLASH_HALF_MS * CYC_PER_MS;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int NUM_OUT = 4;
  localparam int FREQ_W = 16;
  localparam int HYST_W = 12;
  localparam int ST_W = 4;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_STATE = 8'h0C;
  localparam logic [7:0] ADDR_POINT0 = 8'h10;
  localparam logic [7:0] ADDR_RELAYPT = 8'h20;
  localparam logic [7:0] ADDR_LOCKCLR = 8'h24;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] POINT_RST = 32'h0000_0000;
  localparam logic [ST_W-1:0] MASK_RST = 4'h0;

  // control fields
  localparam int CTRL_INV_LSB = 0;
  localparam int CTRL_LOCK_LSB = 4;
  localparam int CTRL_MODE_LSB = 8;
  localparam int CTRL_MODE_W = 4;
  localparam int CTRL_RELAYLOCK_BIT = 12;
  // switch point fields
  localparam int PT_THR_LSB = 0;
  localparam int PT_HYST_LSB = 16;
  localparam int PT_CHSEL_BIT = 30;
  localparam int PT_OVER_BIT = 31;
  // status bits
  localparam int ST_RELAY_FAULT = 0;
  localparam int ST_ERROR = 1;
  localparam int ST_READY = 2;
  localparam int ST_TRIP = 3;

  typedef enum logic [1:0] {
    RUN_NORMAL = 2'b00,
    RUN_PROGRAM = 2'b01,
    RUN_FACTORY = 2'b10
  } sos_run_type;
endpackage

// ===== core/sos_sw_if.sv
// settings and state of one switching point
`timescale 1ns/1ps
`default_nettype none
interface sos_sw_if;
  import sos_pkg::*;
  logic [FREQ_W-1:0] freq;
  logic [FREQ_W-1:0] thresh;
  logic [HYST_W-1:0] hyst;
  logic overSel;
  logic lockEn;
  logic lockClr;
  logic active;
  logic state;
  modport core (output freq, thresh, hyst, overSel, lockEn, lockClr, active, input state);
  modport point (input freq, thresh, hyst, overSel, lockEn, lockClr, active, output state);
endinterface
`default_nettype wire

// ===== core/sos_switch_point.sv
// one frequency switching point with hysteresis and lock
`timescale 1ns/1ps
`default_nettype none
module sos_switch_point (
  input wire logic clk_sys,
  input wire logic reset_n,
  sos_sw_if.point sw
);
  import sos_pkg::*;

  logic state_r;
  logic state_nxt;
  logic [FREQ_W:0] upper;
  logic [FREQ_W:0] lower;
  logic [FREQ_W:0] freqX;
  logic [FREQ_W:0] thrX;

  always_comb begin
    freqX = {1'b0, sw.freq};
    thrX = {1'b0, sw.thresh};
    upper = thrX + (FREQ_W+1)'(sw.hyst);
    lower = (thrX > (FREQ_W+1)'(sw.hyst)) ? thrX - (FREQ_W+1)'(sw.hyst) : '0;
    state_nxt = state_r;
    if (!sw.active) begin
      state_nxt = 1'b0;
    end else if (sw.lockEn && state_r && !sw.lockClr) begin
      state_nxt = 1'b1;
    end else if (sw.overSel) begin
      if (freqX > thrX) begin
        state_nxt = 1'b1;
      end else if (freqX < lower) begin
        state_nxt = 1'b0;
      end
    end else begin
      if (freqX < thrX) begin
        state_nxt = 1'b1;
      end else if (freqX > upper) begin
        state_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign sw.state = state_r;
endmodule
`default_nettype wire

// ===== tb/sos_relay_model.sv
// relay pair with guided feedback contact, as the outside world sees it
`timescale 1ns/1ps
`default_nettype none
module sos_relay_model (
  input wire logic clk_sys,
  input wire logic coilA,
  input wire logic coilB,
  input wire logic [3:0] lag,
  input wire logic stuck,
  output logic contactClosed,
  output logic feedback
);
  logic [3:0] heldCnt_r;

  // armature travel time after both coils pull in
  always_ff @(posedge clk_sys) begin
    if (!(coilA && coilB)) begin
      heldCnt_r <= 4'h0;
    end else if (heldCnt_r != 4'hF) begin
      heldCnt_r <= heldCnt_r + 4'h1;
    end
  end

  // series normally open contacts need both coils
  assign contactClosed = coilA && coilB && (heldCnt_r > lag);
  // guided opener closed while released, or welded when stuck
  assign feedback = stuck || !contactClosed;
endmodule
`default_nettype wire

// ===== tb/safe_output_status_control_tb.sv
// self-checking bench of the safe output and status block
`timescale 1ns/1ps
`default_nettype none
module safe_output_status_control_tb;
  import sos_pkg::*;
  localparam int RS = 20;
  localparam int RL = 60;
  localparam int FH = 4;
  logic clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic runSelectSwitchA, selftestReportSwitch, runSelectSwitchB, relayFeedback;
  logic errorIn, selfTestPass, relayCoilA, relayCoilB, ledYellow, selfTestMsg, irq;
  logic stuck, contactClosed;
  logic [3:0] lag;
  logic [NUM_OUT-1:0] ctrlOut;
  logic [FREQ_W-1:0] freqSinCos1, freqSinCos2, sensorFreq1, sensorFreq2, bridged;
  int n_fail = 0;
  int total_checks = 0;

  sos_output_status #(.READY_SHORT(RS), .READY_LONG(RL), .RELAY_SETTLE(8),
    .FLASH_HALF(FH)) i_dut (.*);
  sos_output_status #(.READY_SHORT(RS), .READY_LONG(RL), .RELAY_SETTLE(8),
    .FLASH_HALF(FH), .SINGLE_ENCODER(1'b1)) i_dut_single (.*, .prdata(), .pready(),
    .pslverr(), .ctrlOut(), .relayCoilA(), .relayCoilB(), .ledYellow(), .selfTestMsg(),
    .sensorFreq1(), .sensorFreq2(bridged), .irq());
  sos_relay_model i_relay (.clk_sys(clk_sys), .coilA(relayCoilA), .coilB(relayCoilB),
    .lag(lag), .stuck(stuck), .contactClosed(contactClosed), .feedback(relayFeedback));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic do_reset(input logic rep);
    selftestReportSwitch <= rep;
    reset_n <= 1'b0;
    cyc(20);
    chk(32'({ledYellow, relayCoilA, relayCoilB, ctrlOut}), 32'h0000_0040);
    reset_n <= 1'b1;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_short_start();
    do_reset(1'b1);
    cyc(10);
    chk(32'({selfTestMsg, ledYellow, relayCoilA}), 32'h0000_0002);
    cyc(RS + 8);
    chk(32'({ledYellow, relayCoilA, relayCoilB, contactClosed}), 32'h0000_0007);
    apb(1'b0, ADDR_CTRL, 32'h0000_0000);
    chk(rd, CTRL_RST);
    apb(1'b0, ADDR_MASK, 32'h0000_0000);
    chk(rd, 32'(MASK_RST));
    apb(1'b1, 8'h30, 32'hFFFF_FFFF);
    chk(32'(err), 32'h0000_0001);
    apb(1'b0, ADDR_STATE, 32'h0000_0000);
    chk(32'(rd[13:10]), 32'h0000_000C);
  endtask

  task automatic t_points();
    freqSinCos1 <= 16'h1234;
    freqSinCos2 <= 16'h5678;
    cyc(3);
    chk({sensorFreq1, sensorFreq2}, 32'h1234_5678);
    chk(32'(bridged), 32'h0000_1234);
    apb(1'b1, ADDR_CTRL, 32'h0000_0100);
    cyc(1);
    chk(32'(bridged), 32'h0000_5678);
    apb(1'b1, ADDR_POINT0, 32'h800A_0064);
    apb(1'b1, ADDR_CTRL, 32'h0000_0002);
    freqSinCos1 <= 16'h0096;
    cyc(5);
    chk(32'(ctrlOut), 32'h0000_0003);
    freqSinCos1 <= 16'h005F;
    cyc(5);
    chk(32'(ctrlOut), 32'h0000_0003);
    freqSinCos1 <= 16'h0055;
    cyc(5);
    chk(32'(ctrlOut), 32'h0000_0002);
    apb(1'b1, ADDR_CTRL, 32'h0000_0012);
    freqSinCos1 <= 16'h0096;
    cyc(5);
    freqSinCos1 <= 16'h0032;
    cyc(5);
    chk(32'(ctrlOut), 32'h0000_0003);
    apb(1'b1, ADDR_LOCKCLR, 32'h0000_0001);
    cyc(3);
    chk(32'(ctrlOut), 32'h0000_0002);
  endtask

  task automatic t_error_irq();
    apb(1'b1, ADDR_CTRL, 32'h0000_000F);
    errorIn <= 1'b1;
    cyc(3);
    chk(32'({ledYellow, relayCoilA, relayCoilB, ctrlOut}), 32'h0000_0040);
    chk(32'(irq), 32'h0000_0000);
    errorIn <= 1'b0;
    apb(1'b1, ADDR_MASK, 32'h0000_0002);
    cyc(1);
    chk(32'(irq), 32'h0000_0001);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk(rd & 32'h0000_0002, 32'h0000_0002);
    apb(1'b1, ADDR_STATUS, 32'h0000_0002);
    cyc(1);
    chk(32'({irq, ctrlOut}), 32'h0000_000F);
  endtask

  task automatic t_relay_trip();
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
    apb(1'b1, ADDR_RELAYPT, 32'h8000_0064);
    lag <= 4'h3;
    freqSinCos1 <= 16'h0096;
    cyc(5);
    chk(32'({relayCoilA, relayCoilB}), 32'h0000_0000);
    freqSinCos1 <= 16'h0032;
    cyc(12);
    chk(32'({relayCoilA, relayCoilB, contactClosed}), 32'h0000_0007);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk(rd & 32'h0000_0009, 32'h0000_0008);
    apb(1'b1, ADDR_RELAYPT, 32'h0000_0000);
    lag <= 4'h0;
  endtask

  task automatic t_run_select();
    logic seen0, seen1, normal;
    for (int i = 0; i < 4; i++) begin
      runSelectSwitchA <= i[1];
      runSelectSwitchB <= i[0];
      normal = i[1] && i[0];
      cyc(6);
      apb(1'b0, ADDR_STATE, 32'h0000_0000);
      chk(32'(rd[11:10]), i[1] ? 32'(!i[0]) : 32'h0000_0002);
      seen0 = 1'b0;
      seen1 = 1'b0;
      repeat (2 * FH + 2) begin
        @(posedge clk_sys);
        seen1 = seen1 | ledYellow;
        seen0 = seen0 | !ledYellow;
      end
      chk(32'({seen1, seen0, relayCoilA}), normal ? 32'h0000_0003 : 32'h0000_0006);
    end
  endtask

  task automatic t_relay_fault();
    apb(1'b1, ADDR_MASK, 32'h0000_0001);
    stuck <= 1'b1;
    cyc(15);
    chk(32'({irq, relayCoilA, relayCoilB}), 32'h0000_0004);
    stuck <= 1'b0;
    cyc(5);
    apb(1'b0, ADDR_STATE, 32'h0000_0000);
    chk(32'({rd[16], relayCoilA}), 32'h0000_0002);
  endtask

  task automatic t_long_start();
    do_reset(1'b0);
    apb(1'b1, ADDR_CTRL, 32'h0000_000F);
    cyc(RS + 8);
    chk(32'({selfTestMsg, ledYellow, relayCoilA, ctrlOut}), 32'h0000_0060);
    cyc(RL - RS);
    chk(32'({selfTestMsg, ledYellow, relayCoilA, ctrlOut}), 32'h0000_001F);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  initial begin
    #500_000;
    n_fail++;
    conclude();
  end

  initial begin
    reset_n = 1'b0;
    {psel, penable, pwrite, errorIn, stuck} = '0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    {runSelectSwitchA, selftestReportSwitch, runSelectSwitchB, selfTestPass} = 4'hF;
    lag = 4'h0;
    freqSinCos1 = 16'h0000;
    freqSinCos2 = 16'h0000;
    @(posedge clk_sys);
    t_short_start();
    t_points();
    t_error_irq();
    t_relay_trip();
    t_run_select();
    t_relay_fault();
    t_long_start();
    conclude();
  end
endmodule
`default_nettype wire
